// ### hw/clock_divider.sv
`timescale 1ns/1ps

module clock_divider #(
  parameter int DIV = 4
) (
  input wire logic sys_clk, // oscillator clock
  input wire logic rst, // synchronous reset, high
  output logic tick, // one-cycle pulse every DIV clocks
  output logic [$clog2(DIV)-1:0] count // position inside the period
);

  localparam logic [$clog2(DIV)-1:0] LAST = ($clog2(DIV))'(DIV - 1);

  logic [$clog2(DIV)-1:0] count_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (count_reg == LAST) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_reg + 1'b1;
    end
  end

  assign tick = (count_reg == LAST);
  assign count = count_reg;

endmodule

// ### hw/cycle_pkg.sv
package cycle_pkg;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int MC_CLOCKS = 4;
  localparam int LEGACY_CLOCKS = 12;
  localparam logic [2:0] STRETCH_RESET = 3'h1;
  localparam logic [3:0] XMOVE_BASE_CYCLES = 4'h2;
  localparam logic TIMER_FAST_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Opcodes with timing that departs from one cycle per byte, plus NOP, ADD immediate and direct to direct move, which keep it
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_DIV = 8'h84;
  localparam logic [7:0] OP_INC_DP = 8'hA3;
  localparam logic [7:0] OP_MOV_DD = 8'h85;
  localparam logic [7:0] OP_LJMP = 8'h02;
  localparam logic [7:0] OP_LCALL = 8'h12;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_RETI = 8'h32;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_JMP_IND = 8'h73;
  localparam logic [7:0] OP_MOVC_DP = 8'h93;
  localparam logic [7:0] OP_MOVC_PC = 8'h83;
  localparam logic [7:0] OP_DJNZ_DIR = 8'hD5;
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_ADD_IMM = 8'h24;

  localparam logic [3:0] CYC_LONGEST = 4'h5;
  localparam logic [3:0] CYC_THREE = 4'h3;
  localparam logic [3:0] CYC_FOUR = 4'h4;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic ext_move;
  } timing_s;

  typedef struct packed {
    logic [15:0] rel_offset;
    logic [10:0] abs_target;
    logic [15:0] long_target;
    logic indirect_valid;
    logic ptr_sel;
  } operand_s;

endpackage

// ### hw/instruction_cycle_timing.sv
`timescale 1ns/1ps

// What this block does
// - Machine cycle lasts exactly four clocks
// - Shortest instructions finish in one cycle
// - No idle cycles between instructions
// - Semantics unchanged, only timing differs
// - Timers tick every twelve clocks after reset
// - Timers selectable to tick every four
// - One address latch strobe per cycle
// - One machine cycle per opcode byte, except jumps, calls, returns, MOVC, INC DPTR, MUL, DIV and external moves
// - External data move takes two cycles minimum
// - Direct to direct move takes three cycles
// - Multiply and divide take five cycles
// - Relative offset is signed byte
// - Indirect operand pointer is R0 or R1
// - Long jump/call carry 16-bit target
// - Absolute jump/call carry 11-bit target
// - Stretch value 0 to 7 programmable
// - Stretch value resets to one
module instruction_cycle_timing (
  input wire logic sys_clk, // oscillator clock
  input wire logic rst, // synchronous reset, high
  input wire logic op_valid, // opcode offered
  input wire logic [7:0] opcode, // opcode byte
  input wire logic [7:0] operand1, // first operand byte
  input wire logic [7:0] operand2, // second operand byte
  output logic op_ready, // opcode accepted this cycle if offered
  input wire logic stretch_we, // load stretch value
  input wire logic [2:0] stretch_in, // new stretch value
  input wire logic timer_mode_we, // load timer rate select
  input wire logic timer_fast_in, // 1 = four clocks per tick
  output logic ale, // address latch strobe
  output logic mc_tick, // last clock of machine cycle
  output logic timer_tick, // timer increment enable
  output logic busy, // instruction executing
  output logic instr_done, // last clock of instruction
  output cycle_pkg::timing_s timing, // timing of current instruction
  output cycle_pkg::operand_s operands, // decoded operand fields
  output logic [2:0] stretch, // active stretch value
  output logic timer_fast // active timer rate
);

  // ----------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------
  logic mc_last;
  logic [1:0] phase;
  logic legacy_tick;

  clock_divider #(.DIV(cycle_pkg::MC_CLOCKS)) u_mc_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(mc_last),
    .count(phase)
  );

  clock_divider #(.DIV(cycle_pkg::LEGACY_CLOCKS)) u_legacy_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(legacy_tick),
    .count()
  );

  // Strobe on the first clock of every cycle, busy or not
  assign ale = (phase == 2'h0);
  assign mc_tick = mc_last;

  // ----------------------------------------------------------------
  // Control settings
  // ----------------------------------------------------------------
  logic [2:0] stretch_reg;
  logic timer_fast_reg;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stretch_reg <= cycle_pkg::STRETCH_RESET;
    end else if (stretch_we) begin
      stretch_reg <= stretch_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timer_fast_reg <= cycle_pkg::TIMER_FAST_RESET;
    end else if (timer_mode_we) begin
      timer_fast_reg <= timer_fast_in;
    end
  end

  // Fast ticks share the machine cycle divider, so they stay aligned
  assign timer_tick = timer_fast_reg ? mc_last : legacy_tick;
  assign stretch = stretch_reg;
  assign timer_fast = timer_fast_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_LJ = cycle_pkg::OP_LJMP;
  localparam logic [7:0] OP_LC = cycle_pkg::OP_LCALL;
  localparam logic [7:0] OP_DV = cycle_pkg::OP_DIV;
  localparam logic [7:0] OP_DD = cycle_pkg::OP_MOV_DD;
  localparam logic [7:0] OP_DJ = cycle_pkg::OP_DJNZ_DIR;

  function automatic logic [1:0] op_bytes(input logic [7:0] op);
    logic [1:0] n;
    n = 2'h1;
    case (op[3:0])
      4'h0: begin
        if (op == 8'h10 || op == 8'h20 || op == 8'h30 || op == 8'h90) begin
          n = 2'h3;
        end else if (op[7:4] != 4'h0 && op[7:5] != 3'h7) begin
          n = 2'h2;
        end
      end
      4'h1: n = 2'h2;
      4'h2: begin
        if (op == OP_LJ || op == OP_LC) begin
          n = 2'h3;
        end else if (op[7:4] >= 4'h4 && op[7:5] != 3'h7) begin
          n = 2'h2;
        end
      end
      4'h3: begin
        if (op[7:4] >= 4'h4 && op[7:4] <= 4'h6) begin
          n = 2'h3;
        end
      end
      4'h4: begin
        if (op[7:4] == 4'hB) begin
          n = 2'h3;
        end else if (op[7:4] >= 4'h2 && op[7:4] <= 4'h9 && op != OP_DV) begin
          n = 2'h2;
        end
      end
      4'h5: begin
        if (op == 8'h75 || op == OP_DD || op == 8'hB5 || op == OP_DJ) begin
          n = 2'h3;
        end else if (op != 8'hA5) begin
          n = 2'h2;
        end
      end
      default: begin
        if (op[7:4] == 4'hB) begin
          n = 2'h3;
        end else if (op[7:4] == 4'h7 || op[7:4] == 4'h8 ||
                     op[7:4] == 4'hA ||
                     (op[7:4] == 4'hD && op[3])) begin
          n = 2'h2;
        end
      end
    endcase
    return n;
  endfunction

  // Only the count of cycles is decided here; the datapath keeps
  // the legacy results and flag effects untouched
  cycle_pkg::timing_s dec;
  logic ext_move;
  logic [3:0] xmove_cycles;

  assign ext_move = (opcode[7:5] == 3'h7) && (opcode[3:0] == 4'h0 ||
                    opcode[3:1] == 3'h1);
  assign xmove_cycles = cycle_pkg::XMOVE_BASE_CYCLES +
                        {1'b0, stretch_reg};

  always_comb begin
    dec.bytes = op_bytes(opcode);
    dec.ext_move = ext_move;
    dec.cycles = {2'h0, dec.bytes};
    if (ext_move) begin
      dec.cycles = xmove_cycles;
    end else if (opcode == cycle_pkg::OP_MUL || opcode == OP_DV) begin
      dec.cycles = cycle_pkg::CYC_LONGEST;
    end else if (opcode == cycle_pkg::OP_INC_DP) begin
      dec.cycles = cycle_pkg::CYC_THREE;
    end else if (opcode == OP_DD) begin
      dec.cycles = cycle_pkg::CYC_THREE;
    end else if (opcode == OP_LJ || opcode == OP_LC ||
                 opcode == cycle_pkg::OP_RET ||
                 opcode == cycle_pkg::OP_RETI ||
                 (opcode[7:4] <= 4'h3 && opcode[3:0] == 4'h0 &&
                  opcode != cycle_pkg::OP_NOP) ||
                 opcode[7:4] == 4'hB && (opcode[3:2] != 2'h0 ||
                 opcode[3:0] == 4'h4 || opcode[3:0] == 4'h5) ||
                 opcode == OP_DJ) begin
      dec.cycles = cycle_pkg::CYC_FOUR;
    end else if (opcode[3:0] == 4'h1 || opcode == cycle_pkg::OP_SJMP ||
                 opcode == cycle_pkg::OP_JMP_IND ||
                 opcode == cycle_pkg::OP_MOVC_DP ||
                 opcode == cycle_pkg::OP_MOVC_PC ||
                 (opcode[7:4] >= 4'h4 && opcode[7:4] <= 4'h7 &&
                  opcode[3:0] == 4'h0) ||
                 (opcode[7:4] == 4'hD && opcode[3])) begin
      dec.cycles = cycle_pkg::CYC_THREE;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic {IDLE, EXEC} seq_e;
  seq_e state_reg;
  logic [3:0] left_reg;
  logic op_take;

  assign instr_done = (state_reg == EXEC) && mc_last && (left_reg == 4'h1);
  // New opcode only at a cycle edge, so no empty cycle is wasted
  assign op_ready = mc_last && (state_reg == IDLE || instr_done);
  assign op_take = op_ready && op_valid;
  assign busy = (state_reg == EXEC);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= IDLE;
    end else if (op_take) begin
      state_reg <= EXEC;
    end else if (instr_done) begin
      state_reg <= IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      left_reg <= 4'h0;
    end else if (op_take) begin
      left_reg <= dec.cycles;
    end else if (busy && mc_last) begin
      left_reg <= left_reg - 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timing <= '0;
    end else if (op_take) begin
      timing <= dec;
    end
  end

  // Operand fields, latched with the opcode
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      operands <= '0;
    end else if (op_take) begin
      operands.rel_offset <= {{8{operand1[7]}}, operand1};
      operands.abs_target <= {opcode[7:5], operand1};
      operands.long_target <= {operand1, operand2};
      operands.indirect_valid <= (opcode[3:1] == 3'h3) && !ext_move;
      operands.ptr_sel <= opcode[0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [5:0] clk_count;
  logic [3:0] gap_count;
  logic slow_settled_reg;

  // First slow gap after a rate change may be short, so skip it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slow_settled_reg <= 1'b1;
    end else if (timer_fast_reg) begin
      slow_settled_reg <= 1'b0;
    end else if (timer_tick) begin
      slow_settled_reg <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || op_take) begin
      clk_count <= 6'h0;
    end else begin
      clk_count <= clk_count + 6'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || timer_tick) begin
      gap_count <= 4'h0;
    end else begin
      gap_count <= gap_count + 4'h1;
    end
  end

  sequence s_take(logic [7:0] op);
    op_take && opcode == op;
  endsequence

  property p_mc_period;
    @(posedge sys_clk) disable iff (rst)
      mc_last |-> ##1 !mc_last [*3] ##1 mc_last;
  endproperty
  a_mc_period: assert property (p_mc_period) else $error("bad cycle");

  property p_ale_once;
    @(posedge sys_clk) disable iff (rst)
      ale |-> ##3 mc_last ##1 ale;
  endproperty
  a_ale_once: assert property (p_ale_once) else $error("bad strobe");

  property p_nop;
    @(posedge sys_clk) disable iff (rst)
      s_take(cycle_pkg::OP_NOP) |-> ##4 instr_done;
  endproperty
  a_nop: assert property (p_nop) else $error("nop not 4 clocks");

  property p_no_idle;
    @(posedge sys_clk) disable iff (rst)
      instr_done && op_valid |-> op_take ##1 busy;
  endproperty
  a_no_idle: assert property (p_no_idle) else $error("idle cycle");

  property p_slow_timer;
    @(posedge sys_clk) disable iff (rst)
      timer_tick && !timer_fast_reg && slow_settled_reg |->
      gap_count == 4'hB;
  endproperty
  a_slow_timer: assert property (p_slow_timer) else $error("timer");

  property p_slow_gap;
    @(posedge sys_clk) disable iff (rst)
      !timer_fast_reg |-> gap_count <= 4'hB;
  endproperty
  a_slow_gap: assert property (p_slow_gap) else $error("slow gap");

  property p_fast_timer;
    @(posedge sys_clk) disable iff (rst)
      timer_tick && timer_fast_reg |-> ##1 (!timer_tick [*3]) ##1
      (timer_tick || !timer_fast_reg);
  endproperty
  a_fast_timer: assert property (p_fast_timer) else $error("fast");

  property p_add_imm;
    @(posedge sys_clk) disable iff (rst)
      s_take(cycle_pkg::OP_ADD_IMM) |-> ##8 instr_done;
  endproperty
  a_add_imm: assert property (p_add_imm) else $error("2 byte");

  property p_done_len;
    @(posedge sys_clk) disable iff (rst)
      instr_done |-> clk_count == {timing.cycles, 2'h0} - 6'h1;
  endproperty
  a_done_len: assert property (p_done_len) else $error("length");

  property p_xmove;
    @(posedge sys_clk) disable iff (rst)
      op_take && ext_move |-> ##1 timing.cycles == 4'h2 + $past(stretch_reg);
  endproperty
  a_xmove: assert property (p_xmove) else $error("xmove");

  property p_mov_dd;
    @(posedge sys_clk) disable iff (rst)
      s_take(OP_DD) |-> ##12 instr_done;
  endproperty
  a_mov_dd: assert property (p_mov_dd) else $error("mov dd");

  property p_mul;
    @(posedge sys_clk) disable iff (rst)
      s_take(cycle_pkg::OP_MUL) |-> ##20 instr_done;
  endproperty
  a_mul: assert property (p_mul) else $error("mul");

  property p_rel;
    @(posedge sys_clk) disable iff (rst)
      op_take |-> ##1
      $signed(operands.rel_offset) == 16'($signed($past(operand1)));
  endproperty
  a_rel: assert property (p_rel) else $error("rel sign");

  property p_long;
    @(posedge sys_clk) disable iff (rst)
      op_take |-> ##1 operands.long_target == {$past(operand1), $past(operand2)};
  endproperty
  a_long: assert property (p_long) else $error("long target");

  property p_incdp;
    @(posedge sys_clk) disable iff (rst)
      s_take(cycle_pkg::OP_INC_DP) |-> ##12 instr_done;
  endproperty
  a_incdp: assert property (p_incdp) else $error("inc dp");

  property p_stretch_reset;
    @(posedge sys_clk)
      rst |-> ##1 stretch_reg == cycle_pkg::STRETCH_RESET;
  endproperty
  a_stretch_reset: assert property (p_stretch_reset) else $error("stretch");

endmodule

// ### verification/prog_mem.sv
`timescale 1ns/1ps

module prog_mem (
  input wire logic sys_clk, // oscillator clock
  input wire logic rst, // synchronous reset, high
  input wire logic slow, // 1 = stall between fetches
  input wire logic op_ready, // core accepts opcode
  output logic op_valid, // opcode offered
  output logic [7:0] opcode, // opcode byte
  output logic [7:0] operand1, // first operand byte
  output logic [7:0] operand2 // second operand byte
);
  typedef struct packed {
    logic [7:0] op;
    logic [7:0] o1;
    logic [7:0] o2;
  } fetch_s;

  fetch_s q[$];
  fetch_s cur;

  // Request held until taken; released lines toggle so stale bytes show
  always @(posedge sys_clk) begin
    if (rst) begin
      op_valid <= 1'b0;
      opcode <= 8'hFF;
      operand1 <= 8'hFF;
      operand2 <= 8'hFF;
    end else if (!op_valid || op_ready === 1'b1) begin
      if (q.size() != 0 && !(slow && $urandom_range(0, 1) == 0)) begin
        cur = q.pop_front();
        op_valid <= 1'b1;
        opcode <= cur.op;
        operand1 <= cur.o1;
        operand2 <= cur.o2;
      end else begin
        op_valid <= 1'b0;
        opcode <= ~opcode;
        operand1 <= ~operand1;
        operand2 <= ~operand2;
      end
    end
  end
endmodule

// ### verification/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  typedef struct packed {
    cycle_pkg::timing_s tim;
    cycle_pkg::operand_s opd;
  } note_s;

  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic op_valid, op_ready, ale, mc_tick, timer_tick, busy, instr_done;
  logic [7:0] opcode, operand1, operand2;
  logic stretch_we = 1'b0;
  logic [2:0] stretch_in = 3'h0;
  logic timer_mode_we = 1'b0;
  logic timer_fast_in = 1'b0;
  logic [2:0] stretch;
  logic timer_fast;
  cycle_pkg::timing_s timing;
  cycle_pkg::operand_s operands;
  note_s notes[$];
  note_s n;
  logic [2:0] cur_stretch = 3'h1;
  int n_errors = 0;
  int checks = 0;
  int cnt = 0;
  int take_at, last_ale, last_tick;
  int exp_gap = 12;
  int skip = 0;
  bit ale_ok, tick_ok;
  logic [7:0] op_list [20] = '{8'h00, 8'h24, 8'h53, 8'h85, 8'hA4,
    8'h84, 8'hA3, 8'h80, 8'h21, 8'hF1, 8'h02, 8'h12, 8'h26, 8'h27,
    8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};

  always #5 sys_clk = ~sys_clk;

  instruction_cycle_timing i_dut (.sys_clk(sys_clk), .rst(rst),
    .op_valid(op_valid), .opcode(opcode), .operand1(operand1),
    .operand2(operand2), .op_ready(op_ready), .stretch_we(stretch_we),
    .stretch_in(stretch_in), .timer_mode_we(timer_mode_we),
    .timer_fast_in(timer_fast_in), .ale(ale), .mc_tick(mc_tick),
    .timer_tick(timer_tick), .busy(busy), .instr_done(instr_done),
    .timing(timing), .operands(operands), .stretch(stretch),
    .timer_fast(timer_fast));

  prog_mem i_mem (.sys_clk(sys_clk), .rst(rst), .slow(slow),
    .op_ready(op_ready), .op_valid(op_valid), .opcode(opcode),
    .operand1(operand1), .operand2(operand2));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic run(input logic [7:0] op);
    note_s e;
    logic [7:0] o1, o2;
    o1 = 8'($urandom);
    o2 = 8'($urandom);
    e.tim = '{bytes: 2'h1, cycles: 4'h1, ext_move: 1'b0};
    case (op)
      8'h24: e.tim = '{bytes: 2'h2, cycles: 4'h2, ext_move: 1'b0};
      8'h53, 8'h85: e.tim = '{bytes: 2'h3, cycles: 4'h3, ext_move: 1'b0};
      8'hA4, 8'h84: e.tim.cycles = 4'h5;
      8'hA3: e.tim.cycles = 4'h3;
      8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3: begin
        e.tim.cycles = 4'h2 + {1'b0, cur_stretch};
        e.tim.ext_move = 1'b1;
      end
      8'h80, 8'h21, 8'hF1: e.tim = '{bytes: 2'h2, cycles: 4'h3,
        ext_move: 1'b0};
      8'h02, 8'h12: e.tim = '{bytes: 2'h3, cycles: 4'h4, ext_move: 1'b0};
      default: ;
    endcase
    e.opd = '{rel_offset: {{8{o1[7]}}, o1}, abs_target: {op[7:5], o1},
      long_target: {o1, o2}, indirect_valid: (op == 8'h26 || op == 8'h27),
      ptr_sel: op[0]};
    notes.push_back(e);
    i_mem.q.push_back({op, o1, o2});
  endtask

  task automatic drain();
    int k;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while ((i_mem.q.size() != 0 || op_valid || busy !== 1'b0 ||
      notes.size() != 0) && k < 3000);
    if (k >= 3000) begin
      n_errors++;
      $display("unexpected stall at %0t got %h exp %h", $time, busy, 1'b0);
    end
  endtask

  task automatic set_stretch(input logic [2:0] v);
    @(posedge sys_clk);
    stretch_we <= 1'b1;
    stretch_in <= v;
    @(posedge sys_clk);
    stretch_we <= 1'b0;
    @(posedge sys_clk);
    cmp(48'(stretch), 48'(v));
    cur_stretch = v;
  endtask

  task automatic set_fast(input logic v);
    @(posedge sys_clk);
    timer_mode_we <= 1'b1;
    timer_fast_in <= v;
    skip = 3;
    exp_gap = v ? 4 : 12;
    @(posedge sys_clk);
    timer_mode_we <= 1'b0;
    @(posedge sys_clk);
    cmp(48'(timer_fast), 48'(v));
  endtask

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  // Sampled before the edge's updates land, so comb outputs are settled
  always @(posedge sys_clk) begin
    cnt++;
    if (rst) begin
      ale_ok = 1'b0;
      tick_ok = 1'b0;
    end else begin
      if (ale === 1'b1) begin
        if (ale_ok) cmp(48'(cnt - last_ale), 48'h4);
        ale_ok = 1'b1;
        last_ale = cnt;
      end
      if (timer_tick === 1'b1) begin
        if (tick_ok && skip > 0) skip--;
        else if (tick_ok) cmp(48'(cnt - last_tick), 48'(exp_gap));
        tick_ok = 1'b1;
        last_tick = cnt;
      end
      if (instr_done === 1'b1) begin
        if (notes.size() == 0) begin
          cmp(48'h1, 48'h0);
        end else begin
          n = notes.pop_front();
          cmp(48'(cnt - take_at), 48'(4 * n.tim.cycles));
          cmp(48'(timing), 48'(n.tim));
          cmp(48'(operands), 48'(n.opd));
          cmp(48'({mc_tick, op_ready}), 48'h3);
        end
      end
      if (op_valid && op_ready === 1'b1) take_at = cnt;
    end
  end

  initial begin
    #200000;
    n_errors++;
    $display("unexpected timeout at %0t got %h exp %h", $time, busy, 1'b0);
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(99));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    cmp(48'({stretch, timer_fast}), 48'h2);
    run(8'hE0);
    drain();
    $display("test reset_defaults done");
    for (int p = 0; p < 2; p++) begin
      slow <= p[0];
      foreach (op_list[i]) run(op_list[i]);
      drain();
    end
    $display("test opcode_table done");
    for (int s = 0; s < 10; s++) begin
      set_stretch(s < 8 ? 3'(s) : 3'($urandom));
      for (int i = 14; i < 20; i++) run(op_list[i]);
      drain();
    end
    $display("test stretch_sweep done");
    repeat (60) @(posedge sys_clk);
    set_fast(1'b1);
    repeat (40) @(posedge sys_clk);
    for (int i = 0; i < 6; i++) run(op_list[i]);
    drain();
    set_fast(1'b0);
    repeat (60) @(posedge sys_clk);
    $display("test timer_rate done");
    end_of_test();
  end
endmodule
